// [acsgc_top.v]
// Purpose: Control frame decode, sequence and general control registers, conversion sequencer
// Assumes: Frames arrive whole as one-cycle strobes, synchronous to clk_sys
// Notes: Reserved bits are not stored and read back as zero
//
// Operation
// R1: Host keeps frame bit 15 low for control register writes.
// R2: Address code 0010 in bits 14..11 writes the sequence register.
// R3: Address code 0011 in bits 14..11 writes the general control register.
// R4: Sequence repeat bit 9 set makes the sequence run continuously.
// R5: Sequence bit 8 set adds the temperature result to the sequence.
// R6: Sequence bits 7..0 each add the matching channel to the sequence.
// R7: Host writes zero to reserved bits of both registers.
// R8: Precharge set with buffer enabled powers buffer only during conversions.
// R9: Precharge clear keeps an enabled buffer powered all the time.
// R10: Buffer enable bit turns the ADC input buffer on or off.
// R11: Lock bit 7 set blocks writes to pin configuration registers.
// R12: Broadcast bit 6 set sends DAC data to every DAC channel.
// R13: Broadcast clear sends DAC data only to the addressed channel.
// R14: Bit 5 selects ADC range: one or two times reference.
// R15: Bit 4 selects DAC range: one or two times reference.
// R16: All functional fields of both registers reset to zero.
// R17: DAC frames have bit 15 high and channel in bits 14..12.
// R18: Channels convert in ascending order, temperature last, restart from lowest.
`include "acsgc_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module acsgc_top (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Control frames from serial host
   input wire [15:0] frame_data,
   input wire frame_valid,
   // Pin mode information
   input wire [7:0] dac_pin_mask,
   // Converter handshake
   input wire seq_trigger,
   input wire conv_done,
   output reg conv_req_q,
   output reg [3:0] conv_slot_q,
   output reg seq_busy_q,
   // Register contents
   output reg [15:0] conversion_sequence_select_q,
   output reg [15:0] converter_general_control_q,
   // Decoded control levels
   output reg adc_buffer_power_q,
   output reg adc_range_double_q,
   output reg dac_range_double_q,
   // Pin configuration write path
   output reg pin_cfg_wr_q,
   output reg [3:0] pin_cfg_addr_q,
   output reg [10:0] pin_cfg_data_q,
   // DAC write path
   output reg [7:0] dac_wr_q,
   output reg [11:0] dac_data_q
);

   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_REQ = 2'd1;
   localparam [1:0] ST_WAIT = 2'd2;

   // Lowest set slot at or above start, none if empty
   function [3:0] next_slot;
      input [8:0] mask;
      input [3:0] start;
      integer i;
      reg found;
      begin
         next_slot = `ACSGC_SLOT_NONE;
         found = 1'b0;
         for (i = 0; i < 9; i = i + 1) begin
            if (!found && mask[i] && (i >= start)) begin
               next_slot = i[3:0];
               found = 1'b1;
            end
         end
      end
   endfunction

   // Pin configuration address check
   function is_pin_cfg;
      input [3:0] addr;
      begin
         case (addr)
            `ACSGC_ADDR_ADC_PINS, `ACSGC_ADDR_DAC_PINS, `ACSGC_ADDR_PULLDOWN,
            `ACSGC_ADDR_GPO_PINS, `ACSGC_ADDR_GPI_PINS, `ACSGC_ADDR_OPENDRAIN,
            `ACSGC_ADDR_TRISTATE: is_pin_cfg = 1'b1;
            default: is_pin_cfg = 1'b0;
         endcase
      end
   endfunction

   // Control frame aimed at one register address
   function is_reg_write;
      input valid;
      input [15:0] frame;
      input [3:0] addr;
      begin
         is_reg_write = valid && !frame[`ACSGC_FRM_TYPE_BIT]
            && (frame[`ACSGC_FRM_ADDR_HI:`ACSGC_FRM_ADDR_LO] == addr);
      end
   endfunction

   // One write strobe for an addressed DAC channel
   function [7:0] chan_onehot;
      input [2:0] chan;
      begin
         chan_onehot = 8'h01 << chan;
      end
   endfunction

   // Frame decode
   wire is_ctl_frame;
   wire is_dac_frame;
   wire [3:0] frm_addr;
   wire [2:0] frm_dac_chan;
   wire wr_seq;
   wire wr_ctl;
   wire lock_on;
   wire bcast_on;
   wire pin_cfg_ok;

   assign is_ctl_frame = frame_valid && !frame_data[`ACSGC_FRM_TYPE_BIT]; // see R1
   assign is_dac_frame = frame_valid && frame_data[`ACSGC_FRM_TYPE_BIT]; // see R17
   assign frm_addr = frame_data[`ACSGC_FRM_ADDR_HI:`ACSGC_FRM_ADDR_LO];
   assign frm_dac_chan = frame_data[`ACSGC_FRM_DACCH_HI:`ACSGC_FRM_DACCH_LO];
   assign wr_seq = is_reg_write(frame_valid, frame_data, `ACSGC_ADDR_SEQ); // see R2
   assign wr_ctl = is_reg_write(frame_valid, frame_data, `ACSGC_ADDR_CTRL); // see R3
   assign lock_on = converter_general_control_q[`ACSGC_CTL_LOCK_BIT];
   assign bcast_on = converter_general_control_q[`ACSGC_CTL_BCAST_BIT];
   assign pin_cfg_ok = is_ctl_frame && is_pin_cfg(frm_addr) && !lock_on; // see R11

   // Sequence register: repeat, temperature, channels; reserved dropped
   always @(posedge clk_sys) begin
      if (srst) begin
         conversion_sequence_select_q <= `ACSGC_SEQ_RESET; // see R16
      end else if (wr_seq) begin
         conversion_sequence_select_q <= {6'h00, frame_data[`ACSGC_SEQ_REPEAT_BIT:0]}; // see R7
      end
   end

   // General control register: bits 9..4 kept, reserved dropped
   always @(posedge clk_sys) begin
      if (srst) begin
         converter_general_control_q <= `ACSGC_CTL_RESET; // see R16
      end else if (wr_ctl) begin
         converter_general_control_q <= {6'h00, frame_data[`ACSGC_CTL_PRECH_BIT:`ACSGC_CTL_DACRNG_BIT],
            4'h0}; // see R7
      end
   end

   // Range selects
   always @(posedge clk_sys) begin
      if (srst) begin
         adc_range_double_q <= 1'b0;
         dac_range_double_q <= 1'b0;
      end else begin
         adc_range_double_q <= converter_general_control_q[`ACSGC_CTL_ADCRNG_BIT]; // see R14
         dac_range_double_q <= converter_general_control_q[`ACSGC_CTL_DACRNG_BIT]; // see R15
      end
   end

   // Pin configuration writes pass only while unlocked
   always @(posedge clk_sys) begin
      if (srst) begin
         pin_cfg_wr_q <= 1'b0;
         pin_cfg_addr_q <= 4'h0;
         pin_cfg_data_q <= 11'h000;
      end else begin
         pin_cfg_wr_q <= pin_cfg_ok;
         if (pin_cfg_ok) begin
            pin_cfg_addr_q <= frm_addr;
            pin_cfg_data_q <= frame_data[10:0];
         end
      end
   end

   // DAC strobes: broadcast to all DAC pins or addressed channel
   reg [7:0] dac_wr_d;

   always @* begin
      dac_wr_d = 8'h00;
      if (is_dac_frame) begin
         if (bcast_on) begin
            dac_wr_d = dac_pin_mask; // see R12
         end else begin
            dac_wr_d = chan_onehot(frm_dac_chan); // see R13
         end
      end
   end

   // DAC data holds the last DAC frame
   always @(posedge clk_sys) begin
      if (srst) begin
         dac_wr_q <= 8'h00;
         dac_data_q <= 12'h000;
      end else begin
         dac_wr_q <= dac_wr_d;
         if (is_dac_frame) begin
            dac_data_q <= frame_data[`ACSGC_FRM_DACDATA_HI:0];
         end
      end
   end

   // Conversion sequencer
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [3:0] slot_d;
   reg load_round_d;
   reg [8:0] round_mask_q;
   reg adc_buffer_power_d;
   wire [8:0] seq_mask;
   wire seq_repeat;
   wire [3:0] first_slot;
   wire [3:0] after_slot;
   wire conv_req_d;
   wire seq_busy_d;

   assign seq_mask = conversion_sequence_select_q[`ACSGC_SEQ_TEMP_BIT:0]; // see R5 see R6
   assign seq_repeat = conversion_sequence_select_q[`ACSGC_SEQ_REPEAT_BIT];
   assign first_slot = next_slot(seq_mask, `ACSGC_SLOT_FIRST);
   assign after_slot = next_slot(round_mask_q, conv_slot_q + 4'h1); // see R18
   assign conv_req_d = (state_d == ST_REQ);
   assign seq_busy_d = (state_d != ST_IDLE);

   always @* begin
      state_d = state_q;
      slot_d = conv_slot_q;
      load_round_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (seq_trigger && (first_slot != `ACSGC_SLOT_NONE)) begin
               state_d = ST_REQ;
               slot_d = first_slot; // see R18
               load_round_d = 1'b1;
            end
         end
         ST_REQ: begin
            state_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (conv_done) begin
               if (after_slot != `ACSGC_SLOT_NONE) begin
                  state_d = ST_REQ;
                  slot_d = after_slot;
               end else if (seq_repeat && (first_slot != `ACSGC_SLOT_NONE)) begin
                  state_d = ST_REQ; // see R4
                  slot_d = first_slot;
                  load_round_d = 1'b1;
               end else begin
                  state_d = ST_IDLE;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         state_q <= ST_IDLE;
         conv_slot_q <= 4'h0;
         conv_req_q <= 1'b0;
         seq_busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         conv_slot_q <= slot_d;
         conv_req_q <= conv_req_d;
         seq_busy_q <= seq_busy_d;
      end
   end

   // Round mask: a register write lands at the start of the next round
   always @(posedge clk_sys) begin
      if (srst) begin
         round_mask_q <= 9'h000;
      end else if (load_round_d) begin
         round_mask_q <= seq_mask; // see R18
      end
   end

   // Buffer power: enable, optionally only while a sequence runs
   always @* begin
      adc_buffer_power_d = 1'b0;
      if (!converter_general_control_q[`ACSGC_CTL_BUFEN_BIT]) begin
         adc_buffer_power_d = 1'b0; // see R10
      end else if (converter_general_control_q[`ACSGC_CTL_PRECH_BIT]) begin
         adc_buffer_power_d = seq_busy_d; // see R8
      end else begin
         adc_buffer_power_d = 1'b1; // see R9
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         adc_buffer_power_q <= 1'b0;
      end else begin
         adc_buffer_power_q <= adc_buffer_power_d;
      end
   end

endmodule

`default_nettype wire

// [acsgc_consts.vh]
// Purpose: Constants for the conversion sequence and general control block
// Assumes: 16-bit control frames, bit 15 low for register writes
// Notes: Definitions only
`ifndef ACSGC_CONSTS_VH
`define ACSGC_CONSTS_VH

// Frame layout
`define ACSGC_FRM_TYPE_BIT 15
`define ACSGC_FRM_ADDR_HI 14
`define ACSGC_FRM_ADDR_LO 11
`define ACSGC_FRM_DACCH_HI 14
`define ACSGC_FRM_DACCH_LO 12
`define ACSGC_FRM_DACDATA_HI 11

// Register addresses
`define ACSGC_ADDR_SEQ 4'h2
`define ACSGC_ADDR_CTRL 4'h3
`define ACSGC_ADDR_ADC_PINS 4'h4
`define ACSGC_ADDR_DAC_PINS 4'h5
`define ACSGC_ADDR_PULLDOWN 4'h6
`define ACSGC_ADDR_GPO_PINS 4'h8
`define ACSGC_ADDR_GPI_PINS 4'ha
`define ACSGC_ADDR_OPENDRAIN 4'hc
`define ACSGC_ADDR_TRISTATE 4'hd

// Sequence register fields
`define ACSGC_SEQ_REPEAT_BIT 9
`define ACSGC_SEQ_TEMP_BIT 8
`define ACSGC_SEQ_CHAN_HI 7

// General control fields
`define ACSGC_CTL_PRECH_BIT 9
`define ACSGC_CTL_BUFEN_BIT 8
`define ACSGC_CTL_LOCK_BIT 7
`define ACSGC_CTL_BCAST_BIT 6
`define ACSGC_CTL_ADCRNG_BIT 5
`define ACSGC_CTL_DACRNG_BIT 4

// Reset values
`define ACSGC_SEQ_RESET 16'h0000
`define ACSGC_CTL_RESET 16'h0000

// Sequence slots
`define ACSGC_SLOT_TEMP 4'h8
`define ACSGC_SLOT_NONE 4'h9
`define ACSGC_SLOT_FIRST 4'h0

`endif

// [acsgc_top_assertions.sv]
// Purpose: Port checks for acsgc_top
// Assumes: srst clears all outputs
// Notes: Bound after the module
`timescale 1ns/10ps
`default_nettype none
module acsgc_top_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Inputs
   input wire logic [15:0] frame_data,
   input wire logic frame_valid,
   input wire logic [7:0] dac_pin_mask,
   // Outputs
   input wire logic conv_req_q,
   input wire logic [3:0] conv_slot_q,
   input wire logic seq_busy_q,
   input wire logic [15:0] conversion_sequence_select_q,
   input wire logic [15:0] converter_general_control_q,
   input wire logic adc_buffer_power_q,
   input wire logic adc_range_double_q,
   input wire logic dac_range_double_q,
   input wire logic pin_cfg_wr_q,
   input wire logic [7:0] dac_wr_q
);
   wire [15:0] gc = converter_general_control_q;
   wire wr = frame_valid && !frame_data[15];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   AST_SEQ_WR: assert property (wr && frame_data[14:11] == 4'h2
      |=> conversion_sequence_select_q == {6'h00, $past(frame_data[9:0])}) else $error("seq write");
   AST_CTL_WR: assert property (wr && frame_data[14:11] == 4'h3
      |=> gc == {6'h00, $past(frame_data[9:4]), 4'h0}) else $error("ctl write");
   AST_DAC_ONE: assert property (frame_valid && frame_data[15] && !gc[6]
      |=> dac_wr_q == 8'h01 << $past(frame_data[14:12])) else $error("dac single");
   AST_DAC_ALL: assert property (frame_valid && frame_data[15] && gc[6]
      |=> dac_wr_q == $past(dac_pin_mask)) else $error("dac all");
   AST_LOCK: assert property (wr && gc[7] |=> !pin_cfg_wr_q) else $error("locked write");
   AST_RANGE: assert property (!$past(srst) |-> {adc_range_double_q, dac_range_double_q} == $past(gc[5:4]))
      else $error("range");
   AST_BUF_ON: assert property (gc[9:8] == 2'b01 |=> adc_buffer_power_q) else $error("buffer on");
   AST_BUF_OFF: assert property (!gc[8] |=> !adc_buffer_power_q) else $error("buffer off");
   AST_BUF_PRE: assert property (gc[9:8] == 2'b11 && $stable(gc) && !seq_busy_q && !$past(seq_busy_q)
      |-> !adc_buffer_power_q) else $error("precharge idle");
   AST_SLOT: assert property (conv_req_q |-> conversion_sequence_select_q[conv_slot_q]) else $error("slot");
   AST_BUF_RUN: assert property (gc[9:8] == 2'b11 && $stable(gc) && seq_busy_q |-> adc_buffer_power_q)
      else $error("precharge run");
   cover property (conv_req_q && conv_slot_q == 4'h8);
   cover property (dac_wr_q != 8'h00 && gc[6]);
   cover property (seq_busy_q && gc[9:8] == 2'b11);
endmodule
bind acsgc_top acsgc_top_assertions u_chk (.*);
`default_nettype wire

// [acsgc_host_model.sv]
// Purpose: Serial host writing frames
// Assumes: One frame per call
// Notes: Idle data is inverted
`timescale 1ns/10ps
`default_nettype none
module acsgc_host_model (
   // Clock
   input wire logic clk_sys,
   // Frames
   output var logic [15:0] frame_data,
   output var logic frame_valid
);
   initial begin
      frame_data = 16'h0000;
      frame_valid = 1'b0;
   end
   task xfer(input logic [15:0] f);
      @(posedge clk_sys);
      frame_data <= f;
      frame_valid <= 1'b1;
      @(posedge clk_sys);
      frame_valid <= 1'b0;
      frame_data <= ~f;
   endtask
   task send(input logic [3:0] a, input logic [10:0] d);
      xfer({1'b0, a, (a == 4'h3) ? (d & 11'h3f0) : (a == 4'h2) ? (d & 11'h3ff) : d});
   endtask
   task dac(input logic [2:0] ch, input logic [11:0] d);
      xfer({1'b1, ch, d});
   endtask
endmodule
`default_nettype wire

// [adc_sequence_and_general_control_test.sv]
// Purpose: Bench for acsgc_top
// Assumes: Seed 19821
// Notes: Results matched in order
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module adc_sequence_and_general_control_test;
   logic clk_sys = 1'b0, srst = 1'b1, seq_trigger = 1'b0, conv_done = 1'b0;
   logic [7:0] dac_pin_mask = 8'h00;
   logic [2:0] dly = 3'h0;
   logic [31:0] e, v, q[$];
   logic [3:0] pa[9] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'ha, 4'hc, 4'hd, 4'h1, 4'hb};
   int seed = 19821, err_count = 0, tests_run = 0, cycles = 0;
   wire frame_valid, conv_req_q, seq_busy_q, adc_buffer_power_q, adc_range_double_q, dac_range_double_q, pin_cfg_wr_q;
   wire [15:0] frame_data, conversion_sequence_select_q, converter_general_control_q;
   wire [3:0] conv_slot_q, pin_cfg_addr_q;
   wire [10:0] pin_cfg_data_q;
   wire [7:0] dac_wr_q;
   wire [11:0] dac_data_q;
   acsgc_host_model host (.*);
   acsgc_top dut (.*);
   always #25 clk_sys = ~clk_sys;
   // Converter answers after 1 to 4 cycles
   always @(posedge clk_sys) begin
      conv_done <= conv_req_q !== 1'b1 && dly == 3'h1;
      if (conv_req_q === 1'b1)
         dly <= 3'h1 + 3'($random(seed) & 3);
      else if (dly != 3'h0)
         dly <= dly - 3'h1;
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         conclude();
      end
   end
   task take(input logic [31:0] g);
      e = q.size() ? q.pop_front() : 32'hffffffff;
      `CHK("result", e, g)
   endtask
   always @(negedge clk_sys) begin
      if (!srst && conv_req_q === 1'b1)
         take({28'h1000000, conv_slot_q});
      if (!srst && dac_wr_q !== 8'h00)
         take({12'h200, dac_wr_q, dac_data_q});
      if (!srst && pin_cfg_wr_q === 1'b1)
         take({5'h06, pin_cfg_addr_q, pin_cfg_data_q, 12'h000});
   end
   task run_seq(input logic [9:0] m);
      host.send(4'h2, {1'b0, m});
      repeat (m[9] ? 2 : 1)
         for (int n = 0; n < 9; n++)
            if (m[n])
               q.push_back({28'h1000000, 4'(n)});
      @(posedge clk_sys);
      seq_trigger <= 1'b1;
      `CHK("seqreg", {6'h00, m}, conversion_sequence_select_q)
      @(posedge clk_sys);
      seq_trigger <= 1'b0;
      wait (q.size() == 0);
      `CHK("bufrun", 1'b1, adc_buffer_power_q)
      wait (seq_busy_q === m[9]);
      $display("test sequence done");
   endtask
   task conclude();
      `CHK("left", 0, q.size())
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      `CHK("ctl", 16'h0000, converter_general_control_q)
      for (int i = 0; i < 8; i++) begin
         v = $random(seed);
         host.send(4'h3, v[10:0]);
         repeat (2) @(negedge clk_sys);
         `CHK("ctl", {6'h00, v[9:4], 4'h0}, converter_general_control_q)
         `CHK("rng", v[5:4], {adc_range_double_q, dac_range_double_q})
         `CHK("buf", v[8] & ~v[9], adc_buffer_power_q)
      end
      $display("test control done");
      for (int k = 0; k < 2; k++) begin
         host.send(4'h3, k ? 11'h080 : 11'h000);
         foreach (pa[i]) begin
            v = $random(seed);
            if (k == 0 && i < 7)
               q.push_back({5'h06, pa[i], v[10:0], 12'h000});
            host.send(pa[i], v[10:0]);
         end
      end
      $display("test lock done");
      for (int k = 0; k < 2; k++) begin
         v = $random(seed);
         @(posedge clk_sys);
         dac_pin_mask <= v[23:16] | 8'h01;
         host.send(4'h3, k ? 11'h000 : 11'h040);
         q.push_back({12'h200, (k ? (8'h01 << v[14:12]) : dac_pin_mask), v[11:0]});
         host.dac(v[14:12], v[11:0]);
      end
      $display("test dac done");
      host.send(4'h3, 11'h300);
      run_seq(10'h105);
      v = $random(seed);
      run_seq({1'b0, v[8:0] | 9'h001});
      run_seq(10'h283);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      `CHK("seq", 16'h0000, conversion_sequence_select_q)
      `CHK("busy", 1'b0, seq_busy_q)
      $display("test reset done");
      conclude();
   end
endmodule
`default_nettype wire
